// ===== core/pcs_core.sv
// program counter sequencing, return stack and indirect address forming
`timescale 1ns/10ps
module pcs_core
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // instruction sequencing
    input  wire pcs_pkg::pcs_op_e     seqOp,
    input  wire logic [10:0]          jumpTarget,
    input  wire logic [7:0]           wrData,
    input  wire logic                 latchWrEn,
    // indirect access from the datapath
    input  wire logic                 indRdEn,
    input  wire logic                 indWrEn,
    input  wire logic [7:0]           pointerWrData,
    input  wire logic                 pointerWrEn,
    input  wire logic [7:0]           statusByte,
    input  wire logic [7:0]           fileRdData,
    // program memory side
    output logic      [12:0]          progAddr,
    output logic      [7:0]           pcLowByte,
    output logic      [7:0]           pcHighLatch,
    // data register file side
    output logic      [8:0]           dataAddr,
    output logic                      fileRdEn,
    output logic                      fileWrEn,
    output logic      [7:0]           indRdData
);
    import pcs_pkg::*;

    // ========================================================================
    // state
    logic [PC_W-1:0]   pc_reg;        // program counter
    logic [PC_W-1:0]   pc_next;       // counter next value
    logic [BYTE_W-1:0] latch_reg;     // high latch, software writable
    logic [BYTE_W-1:0] pointer_reg;   // file select pointer
    logic [PC_W-1:0]   stackTop;      // top of the return stack
    logic              pushEn;        // push strobe
    logic              popEn;         // pop strobe
    logic              selfAccess;    // pointer aims at the port itself

    // ========================================================================
    // return stack; only calls, vectoring and returns touch it
    assign pushEn = (seqOp == PCS_OP_CALL) ||
                    (seqOp == PCS_OP_VECTOR);
    assign popEn  = (seqOp == PCS_OP_RETURN);

    // the pushed value is the counter of this slot, so the sequencer must
    // issue the call or vector in the slot that holds the return address

    pcs_ring_stack u_stack (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .pushEn   (pushEn),
        .popEn    (popEn),
        .pushData (pc_reg),
        .topData  (stackTop)
    );

    // ========================================================================
    // next counter value per operation
    always_comb begin
        pc_next = pc_reg;
        case (seqOp)
            PCS_OP_STEP: begin
                // carry ripples into the upper bits, latch untouched
                pc_next = pc_reg + 13'h0001;
            end
            PCS_OP_HOLD: begin
                pc_next = pc_reg;
            end
            PCS_OP_JUMP, PCS_OP_CALL: begin
                // page bits from latch, rest from the opcode
                pc_next = {latch_reg[LATCH_PAGE+1:LATCH_PAGE], jumpTarget};
            end
            PCS_OP_RETURN: begin
                pc_next = stackTop;          // all 13 bits restored
            end
            PCS_OP_VECTOR: begin
                pc_next = INT_VECTOR;
            end
            PCS_OP_WRLOW: begin
                // upper part copied from latch with the new low byte
                pc_next = {latch_reg[LATCH_W-1:0], wrData};
            end
            default: begin
                pc_next = pc_reg;
            end
        endcase
    end

    // program counter; reset clears every bit including the upper
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_reg <= PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // high latch: only software writes it, never the stack
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latch_reg <= LATCH_RESET;
        end else if (latchWrEn) begin
            latch_reg <= wrData;
        end
    end

    // file select pointer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pointer_reg <= ZERO_BYTE;
        end else if (pointerWrEn) begin
            pointer_reg <= pointerWrData;
        end
    end

    // ========================================================================
    // visible copies; upper counter bits have no read path
    assign progAddr    = pc_reg;
    assign pcLowByte   = pc_reg[BYTE_W-1:0];
    assign pcHighLatch = latch_reg;

    // ========================================================================
    // indirect path: the port holds no storage of its own
    assign selfAccess = (pointer_reg == PORT_ADDR);
    // bank bit above the pointer
    assign dataAddr   = {statusByte[BANK_BIT], pointer_reg};
    // self-aimed read returns zero, self-aimed write is a no-op
    assign fileRdEn   = indRdEn && !selfAccess;
    assign fileWrEn   = indWrEn && !selfAccess;

    // read data registered one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            indRdData <= ZERO_BYTE;
        end else if (indRdEn) begin
            indRdData <= selfAccess ? ZERO_BYTE : fileRdData;
        end
    end

    // ========================================================================
    // checks
    // the stack slots are never cleared, so no check below compares a value
    // popped from a slot that may still be unwritten; returns are judged
    // against the call that fed them instead
    // ------------------------------------------------------------------------
    // counter sequencing

    // a plain step adds one across all thirteen bits
    step_inc_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_STEP |=> pc_reg == $past(pc_reg) + 13'h0001)
        else $error("counter did not advance by one");

    // upper bits move on a step only through the carry out of the low byte
    step_upper_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_STEP && pc_reg[7:0] != 8'hff |=>
            pc_reg[12:8] == $past(pc_reg[12:8]))
        else $error("upper bits moved without a carry");

    // a stall freezes the counter
    hold_pc_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_HOLD |=> $stable(pc_reg))
        else $error("counter moved during a stall");

    // low byte write: latch bits 4:0 go up with the new low byte
    low_write_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_WRLOW |=>
            pc_reg == {$past(latch_reg[4:0]), $past(wrData)})
        else $error("low byte write loaded wrong counter");

    // the written byte reads back through the low byte copy
    low_byte_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_WRLOW |=> pcLowByte == $past(wrData))
        else $error("low byte copy differs from written byte");

    // call and jump: page bits from latch 4:3, the rest from the opcode
    jump_page_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (seqOp == PCS_OP_JUMP || seqOp == PCS_OP_CALL) |=>
            pc_reg == {$past(latch_reg[4:3]), $past(jumpTarget)})
        else $error("jump target page wrong");

    // the eleven opcode bits land unchanged inside the page
    jump_low_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (seqOp == PCS_OP_JUMP || seqOp == PCS_OP_CALL) |=>
            pc_reg[10:0] == $past(jumpTarget))
        else $error("jump target low bits wrong");

    // interrupt vectoring lands on the fixed vector
    vector_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_VECTOR |=> pc_reg == INT_VECTOR)
        else $error("vectoring missed the vector");

    // reset clears the upper counter bits whatever op was pending
    reset_clear_a: assert property (
        @(posedge mclk)
        !rst_n |=> pc_reg[12:8] == 5'h00)
        else $error("upper counter bits not cleared");

    // ------------------------------------------------------------------------
    // return stack

    // a push leaves the current counter on top of the stack
    push_top_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pushEn |=> stackTop == $past(pc_reg))
        else $error("pushed value not on top of stack");

    // a call followed at once by a return restores the call address
    call_ret_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (seqOp == PCS_OP_CALL) ##1 (seqOp == PCS_OP_RETURN) |=>
            pc_reg == $past(pc_reg, 2))
        else $error("return did not restore call address");

    // stack traffic never touches the high latch
    latch_keep_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (pushEn || popEn) && !latchWrEn |=> $stable(latch_reg))
        else $error("latch changed on stack action");

    // a sequential step leaves the high latch alone
    step_latch_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_STEP && !latchWrEn |=> $stable(latch_reg))
        else $error("latch changed on a step");

    // only an explicit write moves the high latch, all eight bits kept
    latch_wr_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        latchWrEn |=> latch_reg == $past(wrData))
        else $error("latch write lost");

    // ------------------------------------------------------------------------
    // indirect path

    // a real target is read through the register file strobe
    file_rd_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        indRdEn && !selfAccess |-> fileRdEn)
        else $error("indirect read did not reach the file");

    // a real target is written through the register file strobe
    file_wr_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        indWrEn && !selfAccess |-> fileWrEn)
        else $error("indirect write did not reach the file");

    // read data comes from the file one edge after the request
    ind_data_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        indRdEn && !selfAccess |=> indRdData == $past(fileRdData))
        else $error("indirect read data wrong");

    // the port read through itself gives zero
    self_read_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        indRdEn && selfAccess |=> indRdData == 8'h00)
        else $error("self read not zero");

    // the port written through itself leaves the file untouched
    self_write_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        indWrEn && selfAccess |-> !fileWrEn)
        else $error("self write reached register file");

    // bank bit sits above the eight pointer bits
    ind_addr_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        dataAddr == {statusByte[BANK_BIT], pointer_reg})
        else $error("indirect address misformed");

    // reset empties the pointer and the read data register
    reset_ind_a: assert property (
        @(posedge mclk)
        !rst_n |=> pointer_reg == ZERO_BYTE && indRdData == ZERO_BYTE)
        else $error("indirect state not cleared by reset");

    // ------------------------------------------------------------------------
    // scenarios

    // call answered at once by a return
    call_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_CALL ##1 seqOp == PCS_OP_RETURN);
    // nine pushes in a row, the ninth on the slot of the first
    wrap_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        pushEn [*8] ##1 pushEn);
    // computed jump through the low byte
    low_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_WRLOW);
    // indirect read aimed at the port itself
    self_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        indRdEn && selfAccess);
    // interrupt vectoring
    vector_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        seqOp == PCS_OP_VECTOR);
endmodule // pcs_core

// ===== core/pcs_pkg.sv
// package of constants for the program counter, return stack and indirect path
// ============================================================================
// ============================================================================
package pcs_pkg;
    // ========================================================================
    // widths
    localparam int PC_W     = 13;   // program counter width
    localparam int BYTE_W   = 8;    // data byte width
    localparam int LATCH_W  = 5;    // used bits of the high latch
    localparam int JUMP_W   = 11;   // target bits carried by call/jump
    localparam int DADDR_W  = 9;    // indirect data address width
    localparam int STK_DEPTH = 8;   // return stack entries
    localparam int STK_PTR_W = 3;   // stack pointer width
    // ========================================================================
    // field positions
    localparam int PAGE_LSB   = 11; // lowest page-select bit of the counter
    localparam int LATCH_PAGE = 3;  // page-select bits start here in latch
    localparam int BANK_BIT   = 7;  // indirect bank bit inside status byte
    // ========================================================================
    // reset values and fixed codes
    localparam logic [PC_W-1:0]    PC_RESET     = 13'h0000;
    localparam logic [PC_W-1:0]    INT_VECTOR   = 13'h0004;
    localparam logic [BYTE_W-1:0]  LATCH_RESET  = 8'h00;
    localparam logic [BYTE_W-1:0]  ZERO_BYTE    = 8'h00;
    localparam logic [BYTE_W-1:0]  PORT_ADDR    = 8'h00; // pointer to itself
    localparam logic [STK_PTR_W-1:0] PTR_RESET  = 3'h0;

    // ========================================================================
    // sequencing operation for one instruction slot
    typedef enum logic [2:0] {
        PCS_OP_STEP,     // plain fetch advance
        PCS_OP_HOLD,     // stall, nothing moves
        PCS_OP_JUMP,     // unconditional jump
        PCS_OP_CALL,     // subroutine call
        PCS_OP_RETURN,   // return, literal return or interrupt return
        PCS_OP_VECTOR,   // interrupt branch to the vector
        PCS_OP_WRLOW     // instruction writes the counter low byte
    } pcs_op_e;
endpackage

// ===== core/pcs_ring_stack.sv
// circular return stack with a hidden pointer
`timescale 1ns/10ps
module pcs_ring_stack
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // push and pop requests
    input  wire logic              pushEn,
    input  wire logic              popEn,
    input  wire logic [pcs_pkg::PC_W-1:0] pushData,
    // top entry
    output logic      [pcs_pkg::PC_W-1:0] topData
);
    import pcs_pkg::*;

    // ========================================================================
    // storage
    logic [PC_W-1:0]      stackMem [STK_DEPTH];   // entries
    logic [STK_PTR_W-1:0] ptr_reg;                // next free slot

    // pointer: wraps silently, no overflow or underflow flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ptr_reg <= PTR_RESET;
        end else if (pushEn) begin
            ptr_reg <= ptr_reg + 3'h1;
        end else if (popEn) begin
            ptr_reg <= ptr_reg - 3'h1;
        end
    end

    // write: ninth push lands on the slot of the first
    always_ff @(posedge mclk) begin
        if (pushEn) begin
            stackMem[ptr_reg] <= pushData;
        end
    end

    // top of stack; unwritten slots read as whatever was there
    assign topData = stackMem[ptr_reg - 3'h1];

    // ------------------------------------------------------------------------
    // checks
    // every push moves on by one, modulo eight, with no stop at full
    stack_wrap_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        pushEn |=> ptr_reg == $past(ptr_reg) + 3'h1)
        else $error("stack pointer did not advance on push");
    // a pop without a push steps back by one, wrapping below slot zero
    pop_step_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        popEn && !pushEn |=> ptr_reg == $past(ptr_reg) - 3'h1)
        else $error("stack pointer did not step back on pop");
    // nothing but a push or a pop may move the hidden pointer
    idle_ptr_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !pushEn && !popEn |=> $stable(ptr_reg))
        else $error("stack pointer moved without push or pop");
endmodule // pcs_ring_stack

// ===== verif/pcs_file_model.sv
// behavioural data register file that answers the core's indirect path
`timescale 1ns/10ps
module pcs_file_model (
    // clock
    input  wire logic       mclk,
    // access from the core
    input  wire logic [8:0] dataAddr,
    input  wire logic       fileRdEn,
    input  wire logic       fileWrEn,
    input  wire logic [7:0] wrValue,
    // answers to the core and the bench
    output logic      [7:0] fileRdData,
    output logic      [7:0] wrCount
);
    // ========================================================================
    // storage
    logic [7:0] mem [512];   // register file contents
    logic [7:0] lastRd;      // last byte driven onto the read bus
    // seeded with a pattern, so a wrong address shows up as wrong data
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        lastRd = 8'h00;
        wrCount = 8'h00;
    end
    // unselected bus shows the inverse of the last byte, never stale data
    assign fileRdData = fileRdEn ? mem[dataAddr] : ~lastRd;
    // writes land on the edge; the count lets the bench spot stray writes
    always @(posedge mclk) begin
        if (fileRdEn) begin
            lastRd <= mem[dataAddr];
        end
        if (fileWrEn) begin
            mem[dataAddr] <= wrValue;
            wrCount <= wrCount + 8'h01;
        end
    end
endmodule // pcs_file_model

// ===== verif/tb.sv
// self-checking bench for counter sequencing, return stack and indirect path
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    mismatches++; $display("mismatch %s exp %h got %h", nm, exp, got); \
    end end
module tb;
    import pcs_pkg::*;
    // ========================================================================
    // stimulus and observed signals
    logic mclk, rst_n, latchWrEn, indRdEn, indWrEn, pointerWrEn;
    pcs_op_e     seqOp;
    logic [10:0] jumpTarget;
    logic [7:0]  wrData, pointerWrData, statusByte, fileRdData, wrCount;
    logic [7:0]  pcLowByte, pcHighLatch, indRdData, wrValue;
    logic [12:0] progAddr;
    logic [8:0]  dataAddr;
    logic        fileRdEn, fileWrEn;
    int          mismatches, checks;
    pcs_core DUT (.mclk(mclk), .rst_n(rst_n), .seqOp(seqOp),
        .jumpTarget(jumpTarget), .wrData(wrData), .latchWrEn(latchWrEn),
        .indRdEn(indRdEn), .indWrEn(indWrEn), .pointerWrData(pointerWrData),
        .pointerWrEn(pointerWrEn), .statusByte(statusByte),
        .fileRdData(fileRdData), .progAddr(progAddr), .pcLowByte(pcLowByte),
        .pcHighLatch(pcHighLatch), .dataAddr(dataAddr), .fileRdEn(fileRdEn),
        .fileWrEn(fileWrEn), .indRdData(indRdData));
    pcs_file_model u_file (.mclk(mclk), .dataAddr(dataAddr),
        .fileRdEn(fileRdEn), .fileWrEn(fileWrEn), .wrValue(wrValue),
        .fileRdData(fileRdData), .wrCount(wrCount));
    // ========================================================================
    // clock, 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // one instruction slot; inputs move 1 ns after the edge
    task automatic op(input pcs_op_e o, input logic [10:0] t);
        seqOp = o;
        jumpTarget = t;
        @(posedge mclk);
        #1;
    endtask
    // latch write during a stalled slot
    task automatic set_latch(input logic [7:0] v);
        wrData = v;
        latchWrEn = 1'b1;
        op(PCS_OP_HOLD, 11'h000);
        latchWrEn = 1'b0;
    endtask
    task automatic load_ptr(input logic [7:0] v);
        pointerWrData = v;
        pointerWrEn = 1'b1;
        op(PCS_OP_HOLD, 11'h000);
        pointerWrEn = 1'b0;
    endtask
    // ========================================================================
    // scenarios
    task automatic t_reset();
        set_latch(8'h1f);
        wrData = 8'h34;
        op(PCS_OP_WRLOW, 11'h000);
        `CHK("progAddr", 13'h1f34, progAddr)
        `CHK("pcLowByte", 8'h34, pcLowByte)
        rst_n = 1'b0;
        op(PCS_OP_STEP, 11'h000);
        rst_n = 1'b1;
        `CHK("progAddr", 13'h0000, progAddr)
        `CHK("pcHighLatch", 8'h00, pcHighLatch)
        $display("test reset done");
    endtask
    task automatic t_step();
        set_latch(8'h06);
        wrData = 8'hfe;
        op(PCS_OP_WRLOW, 11'h000);
        op(PCS_OP_STEP, 11'h000);
        `CHK("progAddr", 13'h06ff, progAddr)
        op(PCS_OP_STEP, 11'h000);
        `CHK("progAddr", 13'h0700, progAddr)
        `CHK("pcLowByte", 8'h00, pcLowByte)
        `CHK("pcHighLatch", 8'h06, pcHighLatch)
        wrData = 8'h10; // table kept inside one 256 block
        op(PCS_OP_WRLOW, 11'h000);
        `CHK("progAddr", 13'h0610, progAddr)
        $display("test step done");
    endtask
    task automatic t_call();
        set_latch(8'h18);
        op(PCS_OP_JUMP, 11'h7ff);
        `CHK("progAddr", 13'h1fff, progAddr)
        op(PCS_OP_CALL, 11'h123);
        `CHK("progAddr", 13'h1923, progAddr)
        op(PCS_OP_RETURN, 11'h000);
        `CHK("progAddr", 13'h1fff, progAddr)
        `CHK("pcHighLatch", 8'h18, pcHighLatch)
        $display("test call done");
    endtask
    task automatic t_ring();
        op(PCS_OP_JUMP, 11'h010);
        for (int j = 2; j <= 10; j++) begin
            op(PCS_OP_CALL, 11'(j * 16));
        end
        for (int k = 9; k >= 2; k--) begin
            op(PCS_OP_RETURN, 11'h000);
            `CHK("pop", 13'h1800 + 13'(k * 16), progAddr)
        end
        op(PCS_OP_RETURN, 11'h000);
        `CHK("wrapped pop", 13'h1890, progAddr)
        $display("test ring done");
    endtask
    task automatic t_vector();
        set_latch(8'h00);
        op(PCS_OP_JUMP, 11'h055);
        op(PCS_OP_VECTOR, 11'h000);
        `CHK("progAddr", INT_VECTOR, progAddr)
        op(PCS_OP_STEP, 11'h000);
        op(PCS_OP_RETURN, 11'h000);
        `CHK("progAddr", 13'h0055, progAddr)
        $display("test vector done");
    endtask
    task automatic t_indirect();
        load_ptr(8'h25);
        statusByte = 8'h80;
        indRdEn = 1'b1;
        #1;
        `CHK("dataAddr", 9'h125, dataAddr)
        `CHK("fileRdEn", 1'b1, fileRdEn)
        op(PCS_OP_HOLD, 11'h000);
        indRdEn = 1'b0;
        `CHK("indRdData", 8'h25 ^ 8'h5a, indRdData)
        load_ptr(8'h00);
        indRdEn = 1'b1;
        indWrEn = 1'b1;
        #1;
        `CHK("fileRdEn", 1'b0, fileRdEn)
        `CHK("fileWrEn", 1'b0, fileWrEn)
        op(PCS_OP_HOLD, 11'h000);
        indRdEn = 1'b0;
        indWrEn = 1'b0;
        `CHK("indRdData", 8'h00, indRdData)
        `CHK("wrCount", 8'h00, wrCount)
        load_ptr(8'h30);
        statusByte = 8'h00;
        indWrEn = 1'b1;
        #1;
        `CHK("dataAddr", 9'h030, dataAddr)
        `CHK("fileWrEn", 1'b1, fileWrEn)
        op(PCS_OP_HOLD, 11'h000);
        indWrEn = 1'b0;
        indRdEn = 1'b1;
        op(PCS_OP_HOLD, 11'h000);
        indRdEn = 1'b0;
        `CHK("indRdData", 8'hc3, indRdData)
        `CHK("wrCount", 8'h01, wrCount)
        $display("test indirect done");
    endtask
    // ========================================================================
    // verdict, reached from the main sequence or the watchdog
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // the tests take under 100 slots; 1000 slots means a hang
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    initial begin
        mismatches = 0;
        checks = 0;
        {rst_n, latchWrEn, indRdEn, indWrEn, pointerWrEn} = 5'h00;
        {wrData, pointerWrData, statusByte, wrValue} = 32'h0000_00c3;
        seqOp = PCS_OP_HOLD;
        jumpTarget = 11'h000;
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_step();
        t_call();
        t_ring();
        t_vector();
        t_indirect();
        give_verdict();
    end
endmodule // tb
